//--- cdh_cmp.sv
// Shared constants and types of the core debug unit, and one comparator unit.
// Assumes the core presents one bus sample per hclk cycle.
`timescale 1ns/1ps

// ************************************************************
// Constants and types
// ************************************************************
package cdh_pkg;
  localparam int NUM_BASIC = 2;
  localparam int CTRL_W = 4;
  localparam int IDX_W = 9;
  localparam int JIDX_W = 8;
  localparam int DR_W = 41;
  localparam int IR_W = 4;
  localparam int SYNC_W = 3;
  localparam int CAUSE_W = 3;
  localparam int EV_W = 3;
  // Word indices; byte address is four times the index
  localparam logic [8:0] IDX_CTRL = 9'h000;
  localparam logic [8:0] IDX_STATUS = 9'h001;
  localparam logic [8:0] IDX_H2T = 9'h002;
  localparam logic [8:0] IDX_T2H = 9'h003;
  localparam logic [8:0] IDX_DCC = 9'h004;
  localparam logic [8:0] IDX_INT_STAT = 9'h005;
  localparam logic [8:0] IDX_INT_EN = 9'h006;
  localparam logic [8:0] IDX_INT_CLR = 9'h007;
  localparam logic [8:0] IDX_CMP_BASE = 9'h008;
  localparam int CMP_SHIFT = 3;
  // Comparator register fields
  localparam logic [2:0] F_ADDR = 3'h0;
  localparam logic [2:0] F_AMASK = 3'h1;
  localparam logic [2:0] F_DATA = 3'h2;
  localparam logic [2:0] F_DMASK = 3'h3;
  localparam logic [2:0] F_CTRL = 3'h4;
  localparam logic [2:0] F_CMASK = 3'h5;
  localparam logic [2:0] F_CFG = 3'h6;
  // Bit positions
  localparam int B_EN = 0;
  localparam int B_BKPT = 1;
  localparam int B_HALT = 0;
  localparam int B_RESTART = 1;
  localparam int B_H2T_FULL = 0;
  localparam int B_T2H_FULL = 1;
  localparam int EV_HALT = 0;
  localparam int EV_H2T = 1;
  localparam int EV_T2H = 2;
  localparam int C_TAG = 0;
  localparam int C_CMP = 1;
  localparam int C_REQ = 2;
  // Scan instructions
  localparam logic [3:0] IR_DEBUG = 4'h2;
  localparam logic [3:0] IR_EXT = 4'h3;
  localparam logic [3:0] IR_RESTART = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hF;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] amask;
    logic [31:0] data;
    logic [31:0] dmask;
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] cmask;
    logic bkpt;
    logic en;
  } cdh_cmp_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [CTRL_W-1:0] ctrl;
    logic fetch;
    logic valid;
  } cdh_bus_s;

  typedef enum logic [1:0] {DBG_RUN, DBG_PEND, DBG_HALT} cdh_dbg_e;

  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PAU_DR, T_EX2_DR, T_UPD_DR,
    T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PAU_IR, T_EX2_IR, T_UPD_IR
  } cdh_tap_e;
endpackage : cdh_pkg

// ************************************************************
// Comparator unit
// ************************************************************
module cdh_cmp (
  input cdh_pkg::cdh_cmp_s cfg,
  input cdh_pkg::cdh_bus_s bus,
  output logic hit
);
  logic addr_eq;
  logic data_eq;
  logic ctrl_eq;

  assign addr_eq = ~|((bus.addr ^ cfg.addr) & ~cfg.amask);
  assign data_eq = ~|((bus.data ^ cfg.data) & ~cfg.dmask);
  assign ctrl_eq = ~|((bus.ctrl ^ cfg.ctrl) & ~cfg.cmask);
  assign hit = cfg.en & bus.valid & (bus.fetch == cfg.bkpt) & addr_eq & data_eq & ctrl_eq;
endmodule : cdh_cmp

//--- cdh_debug_unit.sv
// Core debug unit: halt control, comparators, comms channel, scan access.
// Assumes core signals are on hclk; scan pins are asynchronous.
`timescale 1ns/1ps

// What this block does
// - A tagged fetch is marked and halts the core when it executes.
// - A held halt request enters debug state after the current instruction.
// - The acknowledge output is high whenever the core is in debug state.
// - Two comparators, control, status and comms-channel registers are provided.
// - An enabled comparator halts execution when address, data and control match.
// - Each compared bit has a mask; masked bits are ignored.
// - Each comparator watches data accesses or instruction fetches, as configured.
// - Up to 32 extra comparators sit behind a separate scan chain.
// - The debugger reaches the registers through the scan port.
// - Halting happens only on a comparator hit, a tag, or a request.
module cdh_debug_unit #(
  parameter int NUM_EXT = 0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input cdh_pkg::cdh_bus_s core_bus,
  input wire logic core_exec,
  input wire logic [31:0] core_exec_addr,
  input wire logic core_instr_done,
  input wire logic breakpoint_tag_input,
  input wire logic debug_halt_request,
  output logic debug_state_ack,
  input wire logic jtag_tck,
  input wire logic jtag_tms,
  input wire logic jtag_tdi,
  output logic jtag_tdo,
  output logic jtag_tdo_oe,
  output logic irq
);
  localparam int NCMP = cdh_pkg::NUM_BASIC + NUM_EXT;
  localparam int NS = 2;

  // ************************************************************
  // Pin synchronisers and scan port
  // ************************************************************
  logic [cdh_pkg::SYNC_W-1:0] tck_s_reg, tms_s_reg, tdi_s_reg, req_s_reg;
  logic tck_lvl_reg, tck_lvl_next, req_lvl_reg, req_lvl_next;
  cdh_pkg::cdh_tap_e tap_reg, tap_next;
  logic [cdh_pkg::IR_W-1:0] ir_reg, ir_next, irsh_reg, irsh_next;
  logic [cdh_pkg::DR_W-1:0] drsh_reg, drsh_next;
  logic [cdh_pkg::JIDX_W-1:0] jidx_reg, jidx_next;
  logic tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;
  logic tck_rise, tck_fall, chain_sel;
  logic j_wr, j_cap_t2h, j_restart;
  logic [cdh_pkg::IDX_W-1:0] jeff_idx, jcap_idx;

  assign tck_rise = tck_s_reg[1] & tck_s_reg[2] & ~tck_lvl_reg;
  assign tck_fall = ~tck_s_reg[1] & ~tck_s_reg[2] & tck_lvl_reg;
  assign chain_sel = (ir_reg == cdh_pkg::IR_DEBUG) || (ir_reg == cdh_pkg::IR_EXT);

  function automatic logic [cdh_pkg::IDX_W-1:0] eff_idx(input logic [cdh_pkg::JIDX_W-1:0] i);
    logic [cdh_pkg::IDX_W-1:0] ext_base;
    ext_base = cdh_pkg::IDX_CMP_BASE + 9'(cdh_pkg::NUM_BASIC << cdh_pkg::CMP_SHIFT);
    eff_idx = (ir_reg == cdh_pkg::IR_EXT) ? ext_base + 9'(i) : 9'(i);
  endfunction : eff_idx

  assign jeff_idx = eff_idx(drsh_reg[cdh_pkg::DR_W-2:32]);
  assign jcap_idx = eff_idx(jidx_reg);

  always_comb
  begin
    tck_lvl_next = (tck_s_reg[1] == tck_s_reg[2]) ? tck_s_reg[2] : tck_lvl_reg;
    req_lvl_next = (req_s_reg[1] == req_s_reg[2]) ? req_s_reg[2] : req_lvl_reg;
    tap_next = tap_reg;
    ir_next = ir_reg;
    irsh_next = irsh_reg;
    drsh_next = drsh_reg;
    jidx_next = jidx_reg;
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    j_wr = 1'b0;
    j_cap_t2h = 1'b0;
    j_restart = 1'b0;
    if (tck_rise)
    begin
      case (tap_reg)
        cdh_pkg::T_RESET: tap_next = tms_s_reg[2] ? cdh_pkg::T_RESET : cdh_pkg::T_IDLE;
        cdh_pkg::T_IDLE: tap_next = tms_s_reg[2] ? cdh_pkg::T_SEL_DR : cdh_pkg::T_IDLE;
        cdh_pkg::T_SEL_DR: tap_next = tms_s_reg[2] ? cdh_pkg::T_SEL_IR : cdh_pkg::T_CAP_DR;
        cdh_pkg::T_CAP_DR: tap_next = tms_s_reg[2] ? cdh_pkg::T_EX1_DR : cdh_pkg::T_SH_DR;
        cdh_pkg::T_SH_DR: tap_next = tms_s_reg[2] ? cdh_pkg::T_EX1_DR : cdh_pkg::T_SH_DR;
        cdh_pkg::T_EX1_DR: tap_next = tms_s_reg[2] ? cdh_pkg::T_UPD_DR : cdh_pkg::T_PAU_DR;
        cdh_pkg::T_PAU_DR: tap_next = tms_s_reg[2] ? cdh_pkg::T_EX2_DR : cdh_pkg::T_PAU_DR;
        cdh_pkg::T_EX2_DR: tap_next = tms_s_reg[2] ? cdh_pkg::T_UPD_DR : cdh_pkg::T_SH_DR;
        cdh_pkg::T_UPD_DR: tap_next = tms_s_reg[2] ? cdh_pkg::T_SEL_DR : cdh_pkg::T_IDLE;
        cdh_pkg::T_SEL_IR: tap_next = tms_s_reg[2] ? cdh_pkg::T_RESET : cdh_pkg::T_CAP_IR;
        cdh_pkg::T_CAP_IR: tap_next = tms_s_reg[2] ? cdh_pkg::T_EX1_IR : cdh_pkg::T_SH_IR;
        cdh_pkg::T_SH_IR: tap_next = tms_s_reg[2] ? cdh_pkg::T_EX1_IR : cdh_pkg::T_SH_IR;
        cdh_pkg::T_EX1_IR: tap_next = tms_s_reg[2] ? cdh_pkg::T_UPD_IR : cdh_pkg::T_PAU_IR;
        cdh_pkg::T_PAU_IR: tap_next = tms_s_reg[2] ? cdh_pkg::T_EX2_IR : cdh_pkg::T_PAU_IR;
        cdh_pkg::T_EX2_IR: tap_next = tms_s_reg[2] ? cdh_pkg::T_UPD_IR : cdh_pkg::T_SH_IR;
        cdh_pkg::T_UPD_IR: tap_next = tms_s_reg[2] ? cdh_pkg::T_SEL_DR : cdh_pkg::T_IDLE;
        default: tap_next = cdh_pkg::T_RESET;
      endcase
      case (tap_reg)
        cdh_pkg::T_RESET: ir_next = cdh_pkg::IR_BYPASS;
        cdh_pkg::T_CAP_IR: irsh_next = ir_reg;
        cdh_pkg::T_SH_IR: irsh_next = {tdi_s_reg[2], irsh_reg[cdh_pkg::IR_W-1:1]};
        cdh_pkg::T_UPD_IR: ir_next = irsh_reg;
        cdh_pkg::T_CAP_DR:
        begin
          drsh_next = {1'b0, jidx_reg, rd_word(jcap_idx)};
          j_cap_t2h = chain_sel && (jcap_idx == cdh_pkg::IDX_T2H);
        end
        cdh_pkg::T_SH_DR:
        begin
          if (chain_sel)
            drsh_next = {tdi_s_reg[2], drsh_reg[cdh_pkg::DR_W-1:1]};
          else
            drsh_next = {{(cdh_pkg::DR_W-1){1'b0}}, tdi_s_reg[2]};
        end
        cdh_pkg::T_UPD_DR:
        begin
          jidx_next = drsh_reg[cdh_pkg::DR_W-2:32];
          j_wr = chain_sel && drsh_reg[cdh_pkg::DR_W-1];
        end
        cdh_pkg::T_IDLE: j_restart = (ir_reg == cdh_pkg::IR_RESTART);
        default: ;
      endcase
    end
    if (tck_fall)
    begin
      tdo_oe_next = (tap_reg == cdh_pkg::T_SH_DR) || (tap_reg == cdh_pkg::T_SH_IR);
      tdo_next = (tap_reg == cdh_pkg::T_SH_IR) ? irsh_reg[0] : drsh_reg[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tck_s_reg <= '0;
      tms_s_reg <= '0;
      tdi_s_reg <= '0;
      req_s_reg <= '0;
      tck_lvl_reg <= 1'b0;
      req_lvl_reg <= 1'b0;
      tap_reg <= cdh_pkg::T_RESET;
      ir_reg <= cdh_pkg::IR_BYPASS;
      irsh_reg <= '0;
      drsh_reg <= '0;
      jidx_reg <= '0;
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else
    begin
      tck_s_reg <= {tck_s_reg[1:0], jtag_tck};
      tms_s_reg <= {tms_s_reg[1:0], jtag_tms};
      tdi_s_reg <= {tdi_s_reg[1:0], jtag_tdi};
      req_s_reg <= {req_s_reg[1:0], debug_halt_request};
      tck_lvl_reg <= tck_lvl_next;
      req_lvl_reg <= req_lvl_next;
      tap_reg <= tap_next;
      ir_reg <= ir_next;
      irsh_reg <= irsh_next;
      drsh_reg <= drsh_next;
      jidx_reg <= jidx_next;
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  assign jtag_tdo = tdo_reg;
  assign jtag_tdo_oe = tdo_oe_reg;

  // ************************************************************
  // Register file and bus slave
  // ************************************************************
  cdh_pkg::cdh_cmp_s cmp_reg [NCMP];
  cdh_pkg::cdh_cmp_s cmp_next [NCMP];
  logic [31:0] h2t_reg, h2t_next, t2h_reg, t2h_next, hrdata_reg, hrdata_next;
  logic h2t_full_reg, h2t_full_next, t2h_full_reg, t2h_full_next;
  logic halt_sw_reg, halt_sw_next;
  logic [cdh_pkg::EV_W-1:0] int_stat_reg, int_stat_next, int_en_reg, int_en_next, ev;
  logic dp_wr_reg, dp_wr_next;
  logic [cdh_pkg::IDX_W-1:0] dp_idx_reg, dp_idx_next, ap_idx;
  logic ap_ok, ap_rd, sw_restart;
  logic [NS-1:0] wv;
  logic [cdh_pkg::IDX_W-1:0] wi [NS];
  logic [31:0] wd [NS];
  cdh_pkg::cdh_dbg_e dbg_reg, dbg_next;
  logic [cdh_pkg::CAUSE_W-1:0] cause_reg, cause_next;

  function automatic logic [31:0] rd_word(input logic [cdh_pkg::IDX_W-1:0] i);
    logic [cdh_pkg::IDX_W-1:0] k;
    rd_word = '0;
    k = (i - cdh_pkg::IDX_CMP_BASE) >> cdh_pkg::CMP_SHIFT;
    case (i)
      cdh_pkg::IDX_CTRL: rd_word[cdh_pkg::B_HALT] = halt_sw_reg;
      cdh_pkg::IDX_STATUS: rd_word = {28'h0000000, cause_reg, debug_state_ack};
      cdh_pkg::IDX_H2T: rd_word = h2t_reg;
      cdh_pkg::IDX_T2H: rd_word = t2h_reg;
      cdh_pkg::IDX_DCC: rd_word = {30'h00000000, t2h_full_reg, h2t_full_reg};
      cdh_pkg::IDX_INT_STAT: rd_word = {29'h00000000, int_stat_reg};
      cdh_pkg::IDX_INT_EN: rd_word = {29'h00000000, int_en_reg};
      default:
        for (int c = 0; c < NCMP; c++)
          if (i >= cdh_pkg::IDX_CMP_BASE && k == 9'(c))
            case (i[2:0])
              cdh_pkg::F_ADDR: rd_word = cmp_reg[c].addr;
              cdh_pkg::F_AMASK: rd_word = cmp_reg[c].amask;
              cdh_pkg::F_DATA: rd_word = cmp_reg[c].data;
              cdh_pkg::F_DMASK: rd_word = cmp_reg[c].dmask;
              cdh_pkg::F_CTRL: rd_word = {28'h0000000, cmp_reg[c].ctrl};
              cdh_pkg::F_CMASK: rd_word = {28'h0000000, cmp_reg[c].cmask};
              cdh_pkg::F_CFG: rd_word = {30'h00000000, cmp_reg[c].bkpt, cmp_reg[c].en};
              default: rd_word = '0;
            endcase
    endcase
  endfunction : rd_word

  assign ap_ok = hsel && htrans[1] && hready;
  assign ap_idx = haddr[cdh_pkg::IDX_W+1:2];
  assign ap_rd = ap_ok && !hwrite;
  assign wv = {j_wr, dp_wr_reg};
  assign wi[0] = dp_idx_reg;
  assign wd[0] = hwdata;
  assign wi[1] = jeff_idx;
  assign wd[1] = drsh_reg[31:0];

  always_comb
  begin
    logic [cdh_pkg::IDX_W-1:0] k;
    k = '0;
    cmp_next = cmp_reg;
    h2t_next = h2t_reg;
    t2h_next = t2h_reg;
    halt_sw_next = halt_sw_reg;
    int_en_next = int_en_reg;
    int_stat_next = int_stat_reg;
    h2t_full_next = h2t_full_reg && !(ap_rd && ap_idx == cdh_pkg::IDX_H2T);
    t2h_full_next = t2h_full_reg && !j_cap_t2h;
    sw_restart = 1'b0;
    dp_wr_next = ap_ok && hwrite;
    dp_idx_next = ap_idx;
    hrdata_next = ap_rd ? rd_word(ap_idx) : hrdata_reg;
    for (int s = 0; s < NS; s++)
      if (wv[s])
      begin
        k = (wi[s] - cdh_pkg::IDX_CMP_BASE) >> cdh_pkg::CMP_SHIFT;
        case (wi[s])
          cdh_pkg::IDX_CTRL:
          begin
            halt_sw_next = wd[s][cdh_pkg::B_HALT];
            sw_restart = sw_restart | wd[s][cdh_pkg::B_RESTART];
          end
          cdh_pkg::IDX_H2T:
            if (s == 1)
            begin
              h2t_next = wd[s];
              h2t_full_next = 1'b1;
            end
          cdh_pkg::IDX_T2H:
            if (s == 0)
            begin
              t2h_next = wd[s];
              t2h_full_next = 1'b1;
            end
          cdh_pkg::IDX_INT_EN: int_en_next = wd[s][cdh_pkg::EV_W-1:0];
          cdh_pkg::IDX_INT_CLR: int_stat_next = int_stat_next & ~wd[s][cdh_pkg::EV_W-1:0];
          default:
            for (int c = 0; c < NCMP; c++)
              if (wi[s] >= cdh_pkg::IDX_CMP_BASE && k == 9'(c) && (s == 1 || c < cdh_pkg::NUM_BASIC))
                case (wi[s][2:0])
                  cdh_pkg::F_ADDR: cmp_next[c].addr = wd[s];
                  cdh_pkg::F_AMASK: cmp_next[c].amask = wd[s];
                  cdh_pkg::F_DATA: cmp_next[c].data = wd[s];
                  cdh_pkg::F_DMASK: cmp_next[c].dmask = wd[s];
                  cdh_pkg::F_CTRL: cmp_next[c].ctrl = wd[s][cdh_pkg::CTRL_W-1:0];
                  cdh_pkg::F_CMASK: cmp_next[c].cmask = wd[s][cdh_pkg::CTRL_W-1:0];
                  cdh_pkg::F_CFG:
                  begin
                    cmp_next[c].en = wd[s][cdh_pkg::B_EN];
                    cmp_next[c].bkpt = wd[s][cdh_pkg::B_BKPT];
                  end
                  default: ;
                endcase
        endcase
      end
    ev[cdh_pkg::EV_HALT] = (dbg_next == cdh_pkg::DBG_HALT) && (dbg_reg != cdh_pkg::DBG_HALT);
    ev[cdh_pkg::EV_H2T] = j_wr && (jeff_idx == cdh_pkg::IDX_H2T);
    ev[cdh_pkg::EV_T2H] = j_cap_t2h && t2h_full_reg;
    int_stat_next = int_stat_next | ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_reg <= '{default: '0};
      h2t_reg <= '0;
      t2h_reg <= '0;
      h2t_full_reg <= 1'b0;
      t2h_full_reg <= 1'b0;
      halt_sw_reg <= 1'b0;
      int_stat_reg <= '0;
      int_en_reg <= '0;
      dp_wr_reg <= 1'b0;
      dp_idx_reg <= '0;
      hrdata_reg <= '0;
    end
    else
    begin
      cmp_reg <= cmp_next;
      h2t_reg <= h2t_next;
      t2h_reg <= t2h_next;
      h2t_full_reg <= h2t_full_next;
      t2h_full_reg <= t2h_full_next;
      halt_sw_reg <= halt_sw_next;
      int_stat_reg <= int_stat_next;
      int_en_reg <= int_en_next;
      dp_wr_reg <= dp_wr_next;
      dp_idx_reg <= dp_idx_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign irq = |(int_stat_reg & int_en_reg);

  // ************************************************************
  // Comparators and halt control
  // ************************************************************
  logic [NCMP-1:0] cmp_hit;
  logic tag_vld_reg, tag_vld_next, tag_hit, wp_hit, bp_hit, halt_req, restart;
  logic [31:0] tag_pc_reg, tag_pc_next;

  for (genvar g = 0; g < NCMP; g++)
  begin : g_cmp
    cdh_cmp u_cmp (
      .cfg(cmp_reg[g]),
      .bus(core_bus),
      .hit(cmp_hit[g])
    );
  end

  assign wp_hit = |cmp_hit && !core_bus.fetch;
  assign bp_hit = |cmp_hit && core_bus.fetch;
  assign tag_hit = core_exec && tag_vld_reg && (core_exec_addr == tag_pc_reg);
  assign halt_req = req_lvl_reg || halt_sw_reg;
  assign restart = sw_restart || j_restart;

  always_comb
  begin
    dbg_next = dbg_reg;
    cause_next = cause_reg;
    tag_vld_next = tag_vld_reg && !tag_hit && !restart;
    tag_pc_next = tag_pc_reg;
    if (dbg_reg != cdh_pkg::DBG_HALT && core_bus.valid && core_bus.fetch
        && (breakpoint_tag_input || bp_hit))
    begin
      tag_vld_next = 1'b1;
      tag_pc_next = core_bus.addr;
    end
    case (dbg_reg)
      cdh_pkg::DBG_RUN, cdh_pkg::DBG_PEND:
      begin
        if (tag_hit || ((wp_hit || halt_req || dbg_reg == cdh_pkg::DBG_PEND) && core_instr_done))
          dbg_next = cdh_pkg::DBG_HALT;
        else if (wp_hit || halt_req)
          dbg_next = cdh_pkg::DBG_PEND;
        cause_next = cause_reg | {halt_req, wp_hit, tag_hit};
      end
      cdh_pkg::DBG_HALT:
        if (restart)
        begin
          dbg_next = cdh_pkg::DBG_RUN;
          cause_next = '0;
        end
      default: dbg_next = cdh_pkg::DBG_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dbg_reg <= cdh_pkg::DBG_RUN;
      cause_reg <= '0;
      tag_vld_reg <= 1'b0;
      tag_pc_reg <= '0;
    end
    else
    begin
      dbg_reg <= dbg_next;
      cause_reg <= cause_next;
      tag_vld_reg <= tag_vld_next;
      tag_pc_reg <= tag_pc_next;
    end
  end

  assign debug_state_ack = (dbg_reg == cdh_pkg::DBG_HALT);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  tag_mark_a: assert property (dbg_reg == cdh_pkg::DBG_RUN && core_bus.valid && core_bus.fetch && breakpoint_tag_input |=> tag_vld_reg && tag_pc_reg == $past(core_bus.addr)) else $error("tagged fetch not marked");
  tag_halt_a: assert property (tag_hit && !debug_state_ack |=> debug_state_ack) else $error("tagged instruction did not halt");
  req_pend_a: assert property (dbg_reg == cdh_pkg::DBG_RUN && halt_req && !core_instr_done && !tag_hit |=> dbg_reg == cdh_pkg::DBG_PEND) else $error("request not pended");
  pend_done_a: assert property (dbg_reg == cdh_pkg::DBG_PEND && core_instr_done |=> debug_state_ack) else $error("pending halt missed");
  ack_entry_a: assert property ($rose(debug_state_ack) |-> $past(tag_hit || core_instr_done)) else $error("entered debug state early");
  wp_halt_a: assert property (dbg_reg == cdh_pkg::DBG_RUN && wp_hit |=> dbg_reg != cdh_pkg::DBG_RUN) else $error("watchpoint ignored");
  mask_all_a: assert property (cmp_reg[0].en && cmp_reg[0].amask == '1 && cmp_reg[0].dmask == '1 && cmp_reg[0].cmask == '1 && core_bus.valid && core_bus.fetch == cmp_reg[0].bkpt |-> cmp_hit[0]) else $error("masked bits still compared");
  match_eq_a: assert property (cmp_hit[0] |-> ((core_bus.addr ^ cmp_reg[0].addr) & ~cmp_reg[0].amask) == '0 && ((core_bus.data ^ cmp_reg[0].data) & ~cmp_reg[0].dmask) == '0) else $error("false comparator match");
  mode_sel_a: assert property (cmp_hit[0] |-> core_bus.fetch == cmp_reg[0].bkpt) else $error("comparator mode ignored");
  only_halt_a: assert property (dbg_reg == cdh_pkg::DBG_RUN && !halt_req && !wp_hit && !tag_hit |=> dbg_reg == cdh_pkg::DBG_RUN) else $error("spurious halt");
  jtag_rst_a: assert property (j_restart && debug_state_ack |=> !debug_state_ack) else $error("scan restart ignored");

  tag_c: cover property (tag_hit ##1 debug_state_ack);
  wp_c: cover property (wp_hit ##[1:20] debug_state_ack);
  req_c: cover property (halt_req ##[1:20] debug_state_ack);
  rst_c: cover property (debug_state_ack ##1 !debug_state_ack);
endmodule : cdh_debug_unit

//--- cdh_jtag_host.sv
// Scan host model: drives the test port pins of the debug unit.
// Assumes the unit samples these pins with its own clock.
`timescale 1ns/1ps
// ****
// Scan host
// ****
module cdh_jtag_host (
  output logic jtag_tck,
  output logic jtag_tms,
  output logic jtag_tdi,
  input wire logic jtag_tdo
);
  // Clock stands low outside frames
  initial
  begin
    jtag_tck = 1'b0;
    jtag_tms = 1'b1;
    jtag_tdi = 1'b0;
  end
  task step(input logic m, input logic dv);
    jtag_tms = m;
    jtag_tdi = dv;
    #40 jtag_tck = 1'b1;
    #40 jtag_tck = 1'b0;
  endtask : step
  // From idle: shift n bits LSB first, update, back to idle
  task shift(input logic ir, input logic [40:0] v, input int n);
    step(1'b1, 1'b0);
    if (ir)
      step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++)
      step(i == n - 1, v[i]);
    step(1'b1, ~v[n-1]);
    step(1'b0, v[n-1]);
  endtask : shift
endmodule : cdh_jtag_host

//--- tb_core_debug_halt_watchpoints.sv
// Self-checking bench: bus master, core stimulus and scan host.
// Assumes the package, the debug unit and the scan host compile first.
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb_core_debug_halt_watchpoints;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_exec, core_instr_done;
  logic breakpoint_tag_input, debug_halt_request, debug_state_ack, irq, e;
  logic jtag_tck, jtag_tms, jtag_tdi, jtag_tdo, jtag_tdo_oe;
  logic [31:0] haddr, hwdata, hrdata, core_exec_addr, q, a, d;
  logic [31:0] va [7];
  logic [1:0] htrans;
  logic [2:0] hsize;
  cdh_pkg::cdh_bus_s core_bus;
  int n_fail, checks_done;
  assign hready = hreadyout;
  cdh_debug_unit cdh_debug_unit_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .core_bus(core_bus),
    .core_exec(core_exec),
    .core_exec_addr(core_exec_addr),
    .core_instr_done(core_instr_done),
    .breakpoint_tag_input(breakpoint_tag_input),
    .debug_halt_request(debug_halt_request),
    .debug_state_ack(debug_state_ack),
    .jtag_tck(jtag_tck),
    .jtag_tms(jtag_tms),
    .jtag_tdi(jtag_tdi),
    .jtag_tdo(jtag_tdo),
    .jtag_tdo_oe(jtag_tdo_oe),
    .irq(irq)
  );
  cdh_jtag_host cdh_jtag_host_inst (
    .jtag_tck(jtag_tck),
    .jtag_tms(jtag_tms),
    .jtag_tdi(jtag_tdi),
    .jtag_tdo(jtag_tdo)
  );
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task final_report;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] ev, input logic [31:0] s);
    checks_done++;
    if (s !== ev)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, ev, s);
      n_fail++;
    end
  endtask : chk
  task rdy;
    for (int n = 0; n < 60; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    chk("hready wait", 32'h1, 32'h0);
    final_report;
  endtask : rdy
  task ahb(input logic w, input logic [8:0] i, input logic [31:0] dv);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {21'h0, i, 2'h0};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dv;
    rdy;
    q = hrdata;
  endtask : ahb
  task cyc(input logic v, input logic f, input logic t, input logic x);
    @(posedge hclk);
    core_bus <= '{a, d, 4'h0, f, v};
    breakpoint_tag_input <= t;
    core_exec <= x;
    core_exec_addr <= a;
    core_instr_done <= x;
  endtask : cyc
  task hw(input string nm, input logic ev);
    repeat (8) @(posedge hclk);
    #1 chk(nm, {31'h0, ev}, {31'h0, debug_state_ack});
  endtask : hw
  initial
  begin
    {hresetn, hsel, hwrite, core_exec, core_instr_done, breakpoint_tag_input} = '0;
    {haddr, hwdata, core_exec_addr, a, d, htrans, hsize} = '0;
    debug_halt_request = 1'b0;
    core_bus = '0;
    n_fail = 0;
    checks_done = 0;
    q = $urandom(6);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    hw("ack after reset", 1'b0);
    ahb(1'b1, cdh_pkg::IDX_INT_EN, 32'h1);
    for (int k = 0; k < 5; k++)
    begin
      va = '{$urandom, $urandom & 32'hFFFFFFFE, $urandom, $urandom, 0, 0, {k == 2, k != 4}};
      for (int j = 0; j < 7; j++)
        ahb(1'b1, cdh_pkg::IDX_CMP_BASE + 9'(j), va[j]);
      a = va[0] ^ (va[1] & $urandom) ^ 32'(k == 1);
      d = va[2] ^ (va[3] & $urandom);
      e = (((a ^ va[0]) & ~va[1]) == 0) && (((d ^ va[2]) & ~va[3]) == 0);
      e = (k == 4) || (e && ((k > 1) == va[6][1]) && va[6][0]);
      cyc(1'b1, k > 1, k == 4, 1'b0);
      cyc(1'b0, 1'b0, 1'b0, 1'b1);
      cyc(1'b0, 1'b0, 1'b0, 1'b0);
      hw("comparator or tag halt", e);
      ahb(1'b1, cdh_pkg::IDX_CTRL, 32'h2);
      hw("restart", 1'b0);
    end
    ahb(1'b0, cdh_pkg::IDX_CMP_BASE + 9'h1, 32'h0);
    chk("mask readback", va[1], q);
    @(posedge hclk);
    debug_halt_request <= 1'b1;
    hw("no halt before done", 1'b0);
    cyc(1'b0, 1'b0, 1'b0, 1'b1);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    hw("request halt", 1'b1);
    ahb(1'b0, cdh_pkg::IDX_STATUS, 32'h0);
    #1 chk("status", 32'h9, q);
    chk("irq raised", 32'h1, {31'h0, irq});
    ahb(1'b1, cdh_pkg::IDX_INT_EN, 32'h0);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, cdh_pkg::IDX_INT_CLR, 32'h7);
    ahb(1'b1, cdh_pkg::IDX_INT_EN, 32'h1);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    @(posedge hclk);
    debug_halt_request <= 1'b0;
    repeat (6) @(posedge hclk);
    ahb(1'b1, cdh_pkg::IDX_CTRL, 32'h2);
    hw("released", 1'b0);
    ahb(1'b1, 9'h1F0, $urandom);
    ahb(1'b0, 9'h1F0, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("bus response", 32'h0, {31'h0, hresp});
    d = $urandom;
    cdh_jtag_host_inst.step(1'b0, 1'b0);
    cdh_jtag_host_inst.shift(1'b1, 41'(cdh_pkg::IR_DEBUG), 4);
    cdh_jtag_host_inst.shift(1'b0, {1'b1, 8'(cdh_pkg::IDX_H2T), d}, 41);
    ahb(1'b0, cdh_pkg::IDX_INT_STAT, 32'h0);
    chk("scan event", 32'h2, q & 32'h2);
    ahb(1'b0, cdh_pkg::IDX_H2T, 32'h0);
    chk("scan data", d, q);
    chk("tdo enable idle", 32'h0, {31'h0, jtag_tdo_oe});
    final_report;
  end
endmodule : tb_core_debug_halt_watchpoints
